// File: rtl/sm_trap_pkg.sv
package sm_trap_pkg;
  // Indirect configuration access ports and register index
  localparam logic [15:0] INDEX_PORT = 16'h0022;
  localparam logic [15:0] DATA_PORT = 16'h0023;
  localparam logic [7:0] CFG_ONE_INDEX = 8'hC1;
  localparam logic [7:0] CFG_ONE_RESET = 8'h00;
  localparam int MAIN_MEM_BIT = 3;
  localparam logic [7:0] MAIN_MEM_MASK = 8'h08;
  // Save area layout, dword indices from its base
  localparam logic [31:0] SAVE_AREA_BACK = 32'h0000_0030;
  localparam int SAVE_WORDS = 12;
  localparam int W_INDEX = 0;
  localparam int W_WDATA = 1;
  localparam int W_ADDR_SIZE = 2;
  localparam int W_SMI_BITS = 3;
  localparam int W_CS_LOW = 4;
  localparam int W_CS_HIGH = 5;
  localparam int W_SELECTOR = 6;
  localparam int W_RESUME = 7;
  localparam int W_INTERRUPTED = 8;
  localparam int W_CR0 = 9;
  localparam int W_EFLAGS = 10;
  localparam int W_DR7 = 11;
  localparam int BIT_OUT_DIR = 1;
  localparam int BIT_REP = 2;

  typedef struct packed {
    logic is_out;
    logic has_rep;
    logic [15:0] port;
    logic [15:0] size;
    logic [31:0] wdata;
    logic [31:0] src_index;
    logic [31:0] dst_index;
  } io_trap_t;

  typedef struct packed {
    logic [31:0] cs_low;
    logic [31:0] cs_high;
    logic [15:0] selector;
    logic [31:0] resume_pointer;
    logic [31:0] interrupted_pointer;
    logic [31:0] cr0;
    logic [31:0] eflags;
    logic [31:0] dr7;
  } cpu_state_t;

  typedef enum logic [2:0] {
    ST_NORMAL = 3'b001,
    ST_SAVE = 3'b010,
    ST_SM = 3'b100
  } sm_state_t;
endpackage

// File: rtl/sm_io_trap_save_state.sv
// How it works
// - In SM mode with main-memory access set, data cycles use the normal address strobe.
// - In SM mode with main-memory access clear, SM data cycles use the SM memory strobe.
// - Config register one is reached by index 0C1h on port 22h then data on port 23h.
// - On SM entry after a trap, SMI bits bit 1 records an output (1) or input (0).
// - SMI bits bit 2 records whether the trapped instruction had a repeat prefix.
// - For a trapped output the write size indicator is saved.
// - For a trapped output the 16-bit port address is saved.
// - For a trapped output the 32-bit write data is saved.
// - The index dword holds the source index for an output, else the destination index.
// - The save area starts at SM size minus 30h with the fields in fixed ascending order.
// - Current and next instruction pointers are saved; resume continues at next.
// - The resume instruction leaves SM mode and reloads state incl. CR0, EFLAGS, DR7.
// - Halt is privileged: in a virtual-8086 task it raises a protection fault.
`timescale 1ns/1ps
module sm_io_trap_save_state import sm_trap_pkg::*; #(
  parameter logic [31:0] SM_MEM_BYTES = 32'h0001_0000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Configuration I/O cycles
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [15:0] io_port,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  // Data memory cycle request
  input wire logic mem_req,
  input wire logic mem_in_sm_range,
  output logic normal_addr_strobe_n,
  output logic sm_memory_strobe_n,
  // Interrupt request and trapped instruction context
  input wire logic sm_interrupt_req_n,
  input wire io_trap_t trap_info,
  input wire cpu_state_t cur_state,
  // Resume and halt
  input wire logic resume_from_sm,
  input wire logic halt_exec,
  input wire logic v86_mode,
  output logic prot_fault,
  // Save area port and restored state
  output logic save_we,
  output logic [31:0] save_addr,
  output logic [31:0] save_data,
  output logic in_sm,
  output logic restore_valid,
  output cpu_state_t restore_state
);
  // Save area must fit below the top of SM memory and stay dword aligned
  if (SM_MEM_BYTES < SAVE_AREA_BACK || SM_MEM_BYTES[1:0] != 2'b00) begin : g_bad_size
    $error("SM_MEM_BYTES too small or not dword aligned");
  end

  sm_state_t state, next_state;
  logic [7:0] cfg_one, next_cfg_one;
  logic index_ok, next_index_ok;
  logic [7:0] io_rdata_q, next_io_rdata;
  logic [3:0] wcnt, next_wcnt;
  io_trap_t trap_q, next_trap_q;
  cpu_state_t ctx_q, next_ctx_q;
  logic [31:0] save_mem [SAVE_WORDS];
  logic nas_n, next_nas_n, sms_n, next_sms_n;
  logic fault_q, next_fault;
  logic we_q, next_we;
  logic [31:0] addr_q, next_addr, data_q, next_data;
  logic rv_q, next_rv;
  logic in_sm_q, next_in_sm;
  cpu_state_t rst_q, next_rst;
  logic main_mem;

  function automatic logic [31:0] word_addr(input logic [3:0] w);
    word_addr = SM_MEM_BYTES - SAVE_AREA_BACK + {26'h0, w, 2'b00};
  endfunction

  function automatic logic [31:0] save_word(input logic [3:0] w, input io_trap_t t,
                                            input cpu_state_t c);
    case (w)
      4'h0: save_word = t.is_out ? t.src_index : t.dst_index;
      4'h1: save_word = t.wdata;
      4'h2: save_word = {t.size, t.port};
      4'h3: save_word = {29'h0, t.has_rep, t.is_out, 1'b0};
      4'h4: save_word = c.cs_low;
      4'h5: save_word = c.cs_high;
      4'h6: save_word = {16'h0, c.selector};
      4'h7: save_word = c.resume_pointer;
      4'h8: save_word = c.interrupted_pointer;
      4'h9: save_word = c.cr0;
      4'hA: save_word = c.eflags;
      4'hB: save_word = c.dr7;
      default: save_word = 32'h0000_0000;
    endcase
  endfunction

  assign main_mem = cfg_one[MAIN_MEM_BIT];

  // Configuration register access
  always_comb begin
    next_cfg_one = cfg_one;
    next_index_ok = index_ok;
    next_io_rdata = io_rdata_q;
    if (io_wr && io_port == INDEX_PORT) begin
      next_index_ok = (io_wdata == CFG_ONE_INDEX);
    end else if ((io_wr || io_rd) && io_port == DATA_PORT) begin
      // Index is consumed by one data access, as on the real part
      next_index_ok = 1'b0;
      if (index_ok && io_wr)
        next_cfg_one = io_wdata;
      if (io_rd)
        next_io_rdata = index_ok ? cfg_one : 8'hFF;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_one <= CFG_ONE_RESET;
      index_ok <= 1'b0;
      io_rdata_q <= 8'h00;
    end else begin
      cfg_one <= next_cfg_one;
      index_ok <= next_index_ok;
      io_rdata_q <= next_io_rdata;
    end
  end

  // Strobe selection and halt check
  always_comb begin
    next_nas_n = 1'b1;
    next_sms_n = 1'b1;
    if (mem_req) begin
      if (state == ST_SM && mem_in_sm_range && !main_mem)
        next_sms_n = 1'b0;
      else
        next_nas_n = 1'b0;
    end
    next_fault = halt_exec && v86_mode;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      nas_n <= 1'b1;
      sms_n <= 1'b1;
      fault_q <= 1'b0;
    end else begin
      nas_n <= next_nas_n;
      sms_n <= next_sms_n;
      fault_q <= next_fault;
    end
  end

  // Entry, save sequence and resume
  always_comb begin
    next_state = state;
    next_wcnt = wcnt;
    next_trap_q = trap_q;
    next_ctx_q = ctx_q;
    next_we = 1'b0;
    next_addr = addr_q;
    next_data = data_q;
    next_rv = 1'b0;
    next_rst = rst_q;
    case (state)
      ST_NORMAL: begin
        if (!sm_interrupt_req_n) begin
          next_trap_q = trap_info;
          next_ctx_q = cur_state;
          next_wcnt = 4'h0;
          next_state = ST_SAVE;
        end
      end
      ST_SAVE: begin
        next_we = 1'b1;
        next_addr = word_addr(wcnt);
        next_data = save_word(wcnt, trap_q, ctx_q);
        next_wcnt = wcnt + 4'h1;
        if (wcnt == 4'(SAVE_WORDS - 1))
          next_state = ST_SM;
      end
      ST_SM: begin
        if (resume_from_sm) begin
          next_rst.cs_low = save_mem[W_CS_LOW];
          next_rst.cs_high = save_mem[W_CS_HIGH];
          next_rst.selector = save_mem[W_SELECTOR][15:0];
          next_rst.resume_pointer = save_mem[W_RESUME];
          next_rst.interrupted_pointer = save_mem[W_INTERRUPTED];
          next_rst.cr0 = save_mem[W_CR0];
          next_rst.eflags = save_mem[W_EFLAGS];
          next_rst.dr7 = save_mem[W_DR7];
          next_rv = 1'b1;
          next_state = ST_NORMAL;
        end
      end
      default: next_state = ST_NORMAL;
    endcase
    // Mode flag leaves the block straight from a flop, never from state decode
    next_in_sm = (next_state == ST_SM);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_NORMAL;
      wcnt <= 4'h0;
      trap_q <= '0;
      ctx_q <= '0;
      we_q <= 1'b0;
      addr_q <= 32'h0000_0000;
      data_q <= 32'h0000_0000;
      rv_q <= 1'b0;
      rst_q <= '0;
      in_sm_q <= 1'b0;
    end else begin
      state <= next_state;
      wcnt <= next_wcnt;
      trap_q <= next_trap_q;
      ctx_q <= next_ctx_q;
      we_q <= next_we;
      addr_q <= next_addr;
      data_q <= next_data;
      rv_q <= next_rv;
      rst_q <= next_rst;
      in_sm_q <= next_in_sm;
    end
  end

  // Local image of the save area; handler writes to it are not seen here
  always_ff @(posedge clk) begin
    if (we_q)
      save_mem[4'((addr_q - (SM_MEM_BYTES - SAVE_AREA_BACK)) >> 2)] <= data_q;
  end

  assign io_rdata = io_rdata_q;
  assign normal_addr_strobe_n = nas_n;
  assign sm_memory_strobe_n = sms_n;
  assign prot_fault = fault_q;
  assign save_we = we_q;
  assign save_addr = addr_q;
  assign save_data = data_q;
  assign in_sm = in_sm_q;
  assign restore_valid = rv_q;
  assign restore_state = rst_q;

  a_strobe_main: assert property (@(posedge clk) disable iff (!arst_n)
    (mem_req && state == ST_SM && main_mem) |=> !normal_addr_strobe_n && sm_memory_strobe_n)
    else $error("main memory strobe not used");
  a_strobe_sm: assert property (@(posedge clk) disable iff (!arst_n)
    (mem_req && state == ST_SM && mem_in_sm_range && !main_mem) |=> !sm_memory_strobe_n)
    else $error("SM strobe not used");
  a_strobe_out_sm: assert property (@(posedge clk) disable iff (!arst_n)
    (mem_req && state != ST_SM) |=> !normal_addr_strobe_n && sm_memory_strobe_n)
    else $error("SM strobe used outside SM mode");
  // Both strobes low would make two memories answer the same cycle
  a_strobe_one: assert property (@(posedge clk) disable iff (!arst_n)
    normal_addr_strobe_n || sm_memory_strobe_n)
    else $error("both memory strobes active");
  a_cfg_write: assert property (@(posedge clk) disable iff (!arst_n)
    (io_wr && io_port == DATA_PORT && index_ok) |=> cfg_one == $past(io_wdata))
    else $error("config write lost");
  a_cfg_unarmed: assert property (@(posedge clk) disable iff (!arst_n)
    (io_rd && io_port == DATA_PORT && !index_ok) |=> io_rdata == 8'hFF)
    else $error("unarmed config read not FFh");
  a_cfg_read: assert property (@(posedge clk) disable iff (!arst_n)
    (io_rd && io_port == DATA_PORT && index_ok) |=> io_rdata == $past(cfg_one))
    else $error("config read data wrong");
  a_dir_bit: assert property (@(posedge clk) disable iff (!arst_n)
    (save_we && save_addr == word_addr(4'(W_SMI_BITS))) |->
    save_data[BIT_OUT_DIR] == trap_q.is_out)
    else $error("direction bit wrong");
  a_rep_bit: assert property (@(posedge clk) disable iff (!arst_n)
    (save_we && save_addr == word_addr(4'(W_SMI_BITS))) |->
    save_data[BIT_REP] == trap_q.has_rep)
    else $error("repeat bit wrong");
  a_write_size: assert property (@(posedge clk) disable iff (!arst_n)
    (save_we && save_addr == word_addr(4'(W_ADDR_SIZE))) |-> save_data[31:16] == trap_q.size)
    else $error("write size wrong");
  a_addr_size: assert property (@(posedge clk) disable iff (!arst_n)
    (save_we && save_addr == word_addr(4'(W_ADDR_SIZE))) |->
    save_data == {trap_q.size, trap_q.port})
    else $error("port or size wrong");
  a_write_data: assert property (@(posedge clk) disable iff (!arst_n)
    (save_we && save_addr == word_addr(4'(W_WDATA))) |-> save_data == trap_q.wdata)
    else $error("write data wrong");
  a_index_sel: assert property (@(posedge clk) disable iff (!arst_n)
    (save_we && save_addr == word_addr(4'(W_INDEX))) |->
    save_data == (trap_q.is_out ? trap_q.src_index : trap_q.dst_index))
    else $error("index dword wrong");
  a_save_addr: assert property (@(posedge clk) disable iff (!arst_n)
    save_we |-> save_addr >= word_addr(4'h0) && save_addr <= word_addr(4'(SAVE_WORDS - 1)))
    else $error("save write outside save area");
  a_save_len: assert property (@(posedge clk) disable iff (!arst_n)
    (state == ST_NORMAL && !sm_interrupt_req_n) |=> ##12 in_sm)
    else $error("save sequence length wrong");
  a_curr_ptr: assert property (@(posedge clk) disable iff (!arst_n)
    (save_we && save_addr == word_addr(4'(W_INTERRUPTED))) |->
    save_data == ctx_q.interrupted_pointer)
    else $error("interrupted pointer wrong");
  a_next_ptr: assert property (@(posedge clk) disable iff (!arst_n)
    (save_we && save_addr == word_addr(4'(W_RESUME))) |->
    save_data == ctx_q.resume_pointer)
    else $error("resume pointer wrong");
  a_resume: assert property (@(posedge clk) disable iff (!arst_n)
    (in_sm && resume_from_sm) |=> restore_valid && !in_sm)
    else $error("resume not taken");
  a_trap_hold: assert property (@(posedge clk) disable iff (!arst_n)
    (state != ST_NORMAL) |=> trap_q == $past(trap_q))
    else $error("trap fields changed outside entry");
  a_halt_fault: assert property (@(posedge clk) disable iff (!arst_n)
    (halt_exec && v86_mode) |=> prot_fault)
    else $error("halt in v86 not faulted");
  a_halt_plain: assert property (@(posedge clk) disable iff (!arst_n)
    (halt_exec && !v86_mode) |=> !prot_fault)
    else $error("halt outside v86 faulted");
endmodule // sm_io_trap_save_state

// File: verification/io_trap_chipset.sv
`timescale 1ns/1ps
module io_trap_chipset (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Observed I/O cycles and processor state
  input wire logic io_access,
  input wire logic [15:0] io_port,
  input wire logic [15:0] trap_port,
  input wire logic in_sm,
  // Interrupt request
  output logic sm_interrupt_req_n
);
  // Released once SM is entered, otherwise the request would re-enter after resume
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) sm_interrupt_req_n <= 1'b1;
    else if (in_sm) sm_interrupt_req_n <= 1'b1;
    else if (io_access && io_port == trap_port) sm_interrupt_req_n <= 1'b0;
  end
endmodule // io_trap_chipset

// File: verification/sm_io_trap_save_state_tb.sv
`timescale 1ns/1ps
module sm_io_trap_save_state_tb import sm_trap_pkg::*;;
  localparam logic [31:0] SMB = 32'h0000_1000;
  localparam logic [15:0] TP = 16'h0080;
  logic clk, arst_n, io_wr, io_rd, mem_req, mem_in_sm_range, resume_from_sm;
  logic halt_exec, v86_mode, nas_n, sms_n, req_n, prot_fault, save_we, in_sm;
  logic restore_valid, io_access;
  logic [15:0] io_port;
  logic [7:0] io_wdata, io_rdata;
  logic [31:0] save_addr, save_data;
  io_trap_t trap_info;
  cpu_state_t cur_state, restore_state;
  logic [31:0] sw_addr [12];
  logic [31:0] sw_data [12];
  logic [31:0] exp_w [12];
  int num_errors, n_checks, nsw;

  assign io_access = io_wr | io_rd;
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Saved words are captured as they stream out; extra writes still count
  always @(posedge clk) begin
    if (!arst_n || restore_valid) nsw <= 0;
    else if (save_we) begin
      if (nsw < 12) begin
        sw_addr[nsw] <= save_addr;
        sw_data[nsw] <= save_data;
      end
      nsw <= nsw + 1;
    end
  end

  sm_io_trap_save_state #(.SM_MEM_BYTES(SMB)) i_dut (.clk(clk), .arst_n(arst_n),
    .io_wr(io_wr), .io_rd(io_rd), .io_port(io_port), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .mem_req(mem_req), .mem_in_sm_range(mem_in_sm_range),
    .normal_addr_strobe_n(nas_n), .sm_memory_strobe_n(sms_n),
    .sm_interrupt_req_n(req_n), .trap_info(trap_info), .cur_state(cur_state),
    .resume_from_sm(resume_from_sm), .halt_exec(halt_exec), .v86_mode(v86_mode),
    .prot_fault(prot_fault), .save_we(save_we), .save_addr(save_addr),
    .save_data(save_data), .in_sm(in_sm), .restore_valid(restore_valid),
    .restore_state(restore_state));
  io_trap_chipset i_chipset (.clk(clk), .arst_n(arst_n), .io_access(io_access),
    .io_port(io_port), .trap_port(TP), .in_sm(in_sm), .sm_interrupt_req_n(req_n));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task io_cycle(input logic wr, input logic [15:0] p, input logic [7:0] d);
    @(posedge clk);
    io_wr <= wr;
    io_rd <= !wr;
    io_port <= p;
    io_wdata <= d;
    @(posedge clk);
    io_wr <= 1'b0;
    io_rd <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task cfg_write(input logic [7:0] d);
    io_cycle(1'b1, INDEX_PORT, CFG_ONE_INDEX);
    io_cycle(1'b1, DATA_PORT, d);
  endtask
  task cfg_read(input logic [7:0] e);
    io_cycle(1'b1, INDEX_PORT, CFG_ONE_INDEX);
    io_cycle(1'b0, DATA_PORT, 8'h00);
    check({24'h0, io_rdata}, {24'h0, e});
  endtask
  task mem_cycle(input logic r, input logic en, input logic es);
    @(posedge clk);
    mem_req <= 1'b1;
    mem_in_sm_range <= r;
    @(posedge clk);
    mem_req <= 1'b0;
    #1;
    check({30'h0, nas_n, sms_n}, {30'h0, en, es});
  endtask
  task run_trap(input logic o, input logic rep);
    @(posedge clk);
    trap_info <= {o, rep, TP, 16'h0004, 32'hCAFE_0123, 32'h1111_0000, 32'h2222_0000};
    io_cycle(o, TP, 8'h23);
    for (int i = 0; i < 40 && in_sm !== 1'b1; i++) @(posedge clk);
    #1;
    if (in_sm !== 1'b1) begin
      num_errors++;
      give_verdict();
    end
    exp_w = '{o ? 32'h1111_0000 : 32'h2222_0000, 32'hCAFE_0123, {16'h0004, TP},
      {29'h0, rep, o, 1'b0}, cur_state.cs_low, cur_state.cs_high,
      {16'h0, cur_state.selector}, cur_state.resume_pointer,
      cur_state.interrupted_pointer, cur_state.cr0, cur_state.eflags, cur_state.dr7};
    // Write fields are undefined after an input trap, so they are skipped
    for (int w = 0; w < 12; w++) begin
      check(sw_addr[w], SMB - SAVE_AREA_BACK + 32'(4 * w));
      if (w == 3) check({29'h0, sw_data[3][2:1], 1'b0}, exp_w[3]);
      else if (w == 0) check(sw_data[0], exp_w[0]);
      else if (w == 1) begin
        if (o) check(sw_data[1], exp_w[1]);
      end else if (w == 2) begin
        if (o) check(sw_data[2], exp_w[2]);
      end else check(sw_data[w], exp_w[w]);
    end
  endtask
  task resume;
    @(posedge clk);
    resume_from_sm <= 1'b1;
    @(posedge clk);
    resume_from_sm <= 1'b0;
    #1;
    check({restore_valid, in_sm}, 2'b10);
    check({31'h0, restore_state === cur_state}, 32'h1);
  endtask

  initial begin
    {arst_n, io_wr, io_rd, mem_req, mem_in_sm_range, resume_from_sm} = '0;
    {halt_exec, v86_mode, io_port, io_wdata, trap_info} = '0;
    {num_errors, n_checks} = '0;
    cur_state = {32'hC5C5_0001, 32'hC5C5_0002, 16'h0F00, 32'h0000_1234, 32'h0000_1232,
      32'h6000_0011, 32'h0000_0202, 32'h0000_0400};
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    cfg_read(CFG_ONE_RESET);
    io_cycle(1'b0, DATA_PORT, 8'h00);
    check({24'h0, io_rdata}, 32'hFF);
    cfg_write(MAIN_MEM_MASK);
    cfg_read(MAIN_MEM_MASK);
    cfg_write(8'h00);
    mem_cycle(1'b1, 1'b0, 1'b1);
    $display("test config done");
    run_trap(1'b1, 1'b1);
    mem_cycle(1'b1, 1'b1, 1'b0);
    mem_cycle(1'b0, 1'b0, 1'b1);
    cfg_write(MAIN_MEM_MASK);
    mem_cycle(1'b1, 1'b0, 1'b1);
    cfg_write(8'h00);
    check(nsw, 32'd12);
    resume();
    $display("test output trap done");
    run_trap(1'b0, 1'b0);
    check(nsw, 32'd12);
    resume();
    $display("test input trap done");
    for (int v = 0; v < 2; v++) begin
      @(posedge clk);
      halt_exec <= 1'b1;
      v86_mode <= v[0];
      @(posedge clk);
      halt_exec <= 1'b0;
      #1;
      check({31'h0, prot_fault}, 32'(v));
    end
    $display("test halt done");
    give_verdict();
  end
endmodule // sm_io_trap_save_state_tb
